// ### ucb_pkg.sv
// Package for the serial port control and data buffer block.
package ucb_pkg;
    // Register map on the plain register port.
    localparam logic [3:0] UCB_ADDR_CTRL = 4'h0;
    localparam logic [3:0] UCB_ADDR_DATA = 4'h1;
    localparam logic [3:0] UCB_ADDR_TCTL = 4'h2;
    localparam logic [3:0] UCB_ADDR_BAUD = 4'h3;
    localparam logic [3:0] UCB_ADDR_IEN = 4'h4;
    // Control register field positions.
    localparam int UCB_CTRL_MSH = 7;
    localparam int UCB_CTRL_MSL = 6;
    localparam int UCB_CTRL_MPF = 5;
    localparam int UCB_CTRL_REN = 4;
    localparam int UCB_CTRL_TB9 = 3;
    localparam int UCB_CTRL_RB9 = 2;
    localparam int UCB_CTRL_TDF = 1;
    localparam int UCB_CTRL_RDF = 0;
    // Timer control field positions.
    localparam int UCB_TCTL_DBL = 7;
    localparam int UCB_TCTL_FCLK = 5;
    // Reset values.
    localparam logic [7:0] UCB_RST_CTRL = 8'h00;
    localparam logic [7:0] UCB_RST_DATA = 8'h00;
    localparam logic [7:0] UCB_RST_BAUD = 8'h00;
    // Cycle counts.
    localparam int UCB_DIV12 = 12;
    localparam int UCB_DIV32 = 32;
    localparam int UCB_SAMPLES = 16;
    localparam int UCB_DBL_DIV = 2;
    // Operating modes.
    typedef enum logic [1:0] {
        UCB_MODE_SHIFT = 2'b00,
        UCB_MODE_UART8 = 2'b01,
        UCB_MODE_UART9F = 2'b10,
        UCB_MODE_UART9B = 2'b11
    } ucb_mode_t;
    // Transmit and receive sequencer states.
    typedef enum logic [1:0] {
        UCB_ST_IDLE = 2'b00,
        UCB_ST_START = 2'b01,
        UCB_ST_BITS = 2'b10,
        UCB_ST_STOP = 2'b11
    } ucb_state_t;
endpackage : ucb_pkg

// ### ucb_uart.sv
// Serial port control register, data buffer and bit sequencer.
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ucb_uart (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic baud_tick_i,
    input wire logic serial_in_pin_i,
    output logic serial_out_pin_o,
    output logic irq_o
);
    import ucb_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State of the whole block.
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] tx_buf;
        logic [7:0] rx_buf;
        logic [7:0] tctl;
        logic [7:0] baud_reload;
        logic [7:0] baud_cnt;
        logic ien;
        logic [7:0] rdata;
        logic [5:0] pre_cnt;
        logic [3:0] tx_sub;
        ucb_state_t tx_st;
        logic [3:0] tx_bit;
        logic [9:0] tx_sh;
        logic tx_out;
        logic [3:0] rx_sub;
        ucb_state_t rx_st;
        logic [3:0] rx_bit;
        logic [8:0] rx_sh;
        logic [2:0] rx_smp;
        logic rx_prev;
    } ucb_state_s_t;

    ucb_state_s_t s_q;
    ucb_state_s_t s_d;

    // Majority of three samples taken in the middle of a bit.
    function automatic logic ucb_major(input logic [2:0] v);
        ucb_major = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
    endfunction : ucb_major

    ucb_mode_t mode;
    logic nine;
    logic shift_md;
    logic pre_max;
    logic bit16_tick;
    logic shift_tick;
    logic gen_tick;
    logic [5:0] fixed_div;

    ////////////////////////////////////////////////////////////////////////
    // Rate generation; every rate is a one-cycle enable.
    always_comb begin
        mode = ucb_mode_t'({s_q.ctrl[UCB_CTRL_MSH], s_q.ctrl[UCB_CTRL_MSL]});
        nine = s_q.ctrl[UCB_CTRL_MSH];
        shift_md = (mode == UCB_MODE_SHIFT);
        // Fixed mode: sixteen samples per bit, so 2 or 4 clocks a sample.
        fixed_div = s_q.tctl[UCB_TCTL_DBL] ? 6'(UCB_DIV32 / UCB_SAMPLES)
                                           : 6'(UCB_DBL_DIV * UCB_DIV32 / UCB_SAMPLES);
        // Generated rate: reload timer overflow, passed only while pre_cnt bit 0 is set unless doubled.
        gen_tick = baud_tick_i && (s_q.baud_cnt == 8'hFF)
                   && (s_q.tctl[UCB_TCTL_DBL] || s_q.pre_cnt[0]);
        pre_max = 1'b0;
        unique case (mode)
            UCB_MODE_SHIFT: pre_max = (s_q.pre_cnt == 6'(UCB_DIV12 - 1));
            UCB_MODE_UART9F: pre_max = (s_q.pre_cnt == fixed_div - 6'd1);
            UCB_MODE_UART8, UCB_MODE_UART9B: pre_max = 1'b0;
        endcase
        // Shift clock: full clock when filter bit set, else over 12.
        shift_tick = s_q.ctrl[UCB_CTRL_MPF] ? 1'b1 : pre_max;
        bit16_tick = (mode == UCB_MODE_UART9F) ? pre_max : gen_tick;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic: registers, transmitter and receiver.
    always_comb begin
        logic rx_bitval;
        logic rx_ok;
        logic tx_set;
        logic rx_set;
        logic clr_t;
        logic clr_r;
        rx_bitval = 1'b0;
        rx_ok = 1'b0;
        tx_set = 1'b0;
        rx_set = 1'b0;
        clr_t = 1'b0;
        clr_r = 1'b0;
        s_d = s_q;
        s_d.rdata = 8'h00;

        // Prescaler and reload timer.
        if (pre_max || (!shift_md && mode != UCB_MODE_UART9F && gen_tick)) begin
            s_d.pre_cnt = (mode == UCB_MODE_UART9F || shift_md) ? 6'd0 : s_q.pre_cnt + 6'd1;
        end else if (shift_md || mode == UCB_MODE_UART9F) begin
            s_d.pre_cnt = s_q.pre_cnt + 6'd1;
        end
        if (baud_tick_i) begin
            s_d.baud_cnt = (s_q.baud_cnt == 8'hFF) ? s_q.baud_reload : s_q.baud_cnt + 8'd1;
        end

        // Register writes; the done flags are only cleared by software.
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                UCB_ADDR_CTRL: begin
                    s_d.ctrl = reg_wdata_i;
                    clr_t = !reg_wdata_i[UCB_CTRL_TDF];
                    clr_r = !reg_wdata_i[UCB_CTRL_RDF];
                end
                UCB_ADDR_DATA: begin
                    s_d.tx_buf = reg_wdata_i;
                    // Writing the buffer launches a frame.
                    s_d.tx_st = UCB_ST_START;
                    s_d.tx_sub = 4'd0;
                    s_d.tx_bit = 4'd0;
                    s_d.tx_sh = {nine ? s_q.ctrl[UCB_CTRL_TB9] : 1'b1, reg_wdata_i, 1'b0};
                end
                UCB_ADDR_TCTL: s_d.tctl = reg_wdata_i;
                UCB_ADDR_BAUD: s_d.baud_reload = reg_wdata_i;
                UCB_ADDR_IEN: s_d.ien = reg_wdata_i[0];
                default: ;
            endcase
        end
        s_d.ctrl[UCB_CTRL_TDF] = s_q.ctrl[UCB_CTRL_TDF] & !clr_t;
        s_d.ctrl[UCB_CTRL_RDF] = s_q.ctrl[UCB_CTRL_RDF] & !clr_r;
        if (reg_wr_i && reg_addr_i == UCB_ADDR_CTRL) begin
            s_d.ctrl[UCB_CTRL_TB9] = reg_wdata_i[UCB_CTRL_TB9];
        end

        // Transmitter; runs alone of the receiver in async modes.
        if (shift_md && s_q.tx_st != UCB_ST_IDLE && shift_tick) begin
            s_d.tx_out = s_q.tx_sh[1];
            s_d.tx_sh = {1'b1, s_q.tx_sh[9:1]};
            s_d.tx_bit = s_q.tx_bit + 4'd1;
            s_d.tx_st = UCB_ST_BITS;
            if (s_q.tx_bit == 4'd8) begin
                s_d.tx_st = UCB_ST_IDLE;
                s_d.tx_out = 1'b1;
                tx_set = 1'b1;
            end
        end else if (!shift_md && s_q.tx_st != UCB_ST_IDLE && bit16_tick) begin
            s_d.tx_sub = s_q.tx_sub + 4'd1;
            if (s_q.tx_sub == 4'd0) begin
                unique case (s_q.tx_st)
                    UCB_ST_START: begin
                        s_d.tx_out = 1'b0;
                        s_d.tx_st = UCB_ST_BITS;
                    end
                    UCB_ST_BITS: begin
                        s_d.tx_out = s_q.tx_sh[1];
                        s_d.tx_sh = {1'b1, s_q.tx_sh[9:1]};
                        s_d.tx_bit = s_q.tx_bit + 4'd1;
                        if (s_q.tx_bit == (nine ? 4'd8 : 4'd7)) begin
                            s_d.tx_st = UCB_ST_STOP;
                        end
                    end
                    UCB_ST_STOP: begin
                        s_d.tx_out = 1'b1;
                        s_d.tx_st = UCB_ST_IDLE;
                        tx_set = 1'b1;
                    end
                    default: s_d.tx_st = UCB_ST_IDLE;
                endcase
            end
        end

        // Receiver.
        s_d.rx_prev = serial_in_pin_i;
        if (!s_q.ctrl[UCB_CTRL_REN]) begin
            s_d.rx_st = UCB_ST_IDLE;
        end else if (shift_md) begin
            // Shift mode receives once enabled and the flag is clear.
            if (s_q.rx_st == UCB_ST_IDLE && !s_q.ctrl[UCB_CTRL_RDF]) begin
                s_d.rx_st = UCB_ST_BITS;
                s_d.rx_bit = 4'd0;
            end else if (s_q.rx_st == UCB_ST_BITS && shift_tick) begin
                s_d.rx_sh = {serial_in_pin_i, s_q.rx_sh[8:1]};
                s_d.rx_bit = s_q.rx_bit + 4'd1;
                if (s_q.rx_bit == 4'd7) begin
                    s_d.rx_st = UCB_ST_STOP;
                    s_d.rx_buf = {serial_in_pin_i, s_q.rx_sh[8:2]};
                    rx_set = 1'b1;
                end
            end
        end else if (s_q.rx_st == UCB_ST_IDLE) begin
            if (s_q.rx_prev && !serial_in_pin_i) begin
                s_d.rx_st = UCB_ST_START;
                s_d.rx_sub = 4'd0;
                s_d.rx_bit = 4'd0;
            end
        end else if (bit16_tick) begin
            s_d.rx_sub = s_q.rx_sub + 4'd1;
            if (s_q.rx_sub >= 4'd7 && s_q.rx_sub <= 4'd9) begin
                s_d.rx_smp = {s_q.rx_smp[1:0], serial_in_pin_i};
            end
            rx_bitval = ucb_major(s_q.rx_smp);
            if (s_q.rx_sub == 4'd10) begin
                unique case (s_q.rx_st)
                    UCB_ST_START: begin
                        s_d.rx_st = rx_bitval ? UCB_ST_IDLE : UCB_ST_BITS;
                    end
                    UCB_ST_BITS: begin
                        s_d.rx_sh = {rx_bitval, s_q.rx_sh[8:1]};
                        s_d.rx_bit = s_q.rx_bit + 4'd1;
                        if (s_q.rx_bit == (nine ? 4'd8 : 4'd7)) begin
                            s_d.rx_st = nine ? UCB_ST_IDLE : UCB_ST_STOP;
                        end
                        if (nine && s_q.rx_bit == 4'd8) begin
                            // Ninth bit ends the frame for the flag.
                            rx_ok = !s_q.ctrl[UCB_CTRL_RDF]
                                    && (!s_q.ctrl[UCB_CTRL_MPF] || rx_bitval);
                            if (rx_ok) begin
                                s_d.rx_buf = s_q.rx_sh[8:1];
                                s_d.ctrl[UCB_CTRL_RB9] = rx_bitval;
                                rx_set = 1'b1;
                            end
                        end
                    end
                    UCB_ST_STOP: begin
                        s_d.rx_st = UCB_ST_IDLE;
                        rx_ok = !s_q.ctrl[UCB_CTRL_RDF]
                                && (!s_q.ctrl[UCB_CTRL_MPF] || rx_bitval);
                        if (rx_ok) begin
                            s_d.rx_buf = s_q.rx_sh[8:1];
                            s_d.ctrl[UCB_CTRL_RB9] = rx_bitval;
                            rx_set = 1'b1;
                        end
                    end
                    default: s_d.rx_st = UCB_ST_IDLE;
                endcase
            end
        end
        // Shift mode stays parked after a byte until the flag drops.
        if (shift_md && s_q.rx_st == UCB_ST_STOP && !s_q.ctrl[UCB_CTRL_RDF] && !rx_set) begin
            s_d.rx_st = UCB_ST_IDLE;
        end

        // Hardware set beats a software clear in the same cycle.
        if (tx_set) begin
            s_d.ctrl[UCB_CTRL_TDF] = 1'b1;
        end
        if (rx_set) begin
            s_d.ctrl[UCB_CTRL_RDF] = 1'b1;
        end

        // Read data stand in the cycle after the strobe.
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                UCB_ADDR_CTRL: s_d.rdata = s_q.ctrl;
                UCB_ADDR_DATA: s_d.rdata = s_q.rx_buf;
                UCB_ADDR_TCTL: s_d.rdata = s_q.tctl;
                UCB_ADDR_BAUD: s_d.rdata = s_q.baud_reload;
                UCB_ADDR_IEN: s_d.rdata = {7'h00, s_q.ien};
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_q <= '0;
            s_q.ctrl <= UCB_RST_CTRL;
            s_q.tx_buf <= UCB_RST_DATA;
            s_q.rx_buf <= UCB_RST_DATA;
            s_q.baud_reload <= UCB_RST_BAUD;
            s_q.baud_cnt <= UCB_RST_BAUD;
            s_q.tx_sh <= 10'h3FF;
            s_q.tx_out <= 1'b1;
            s_q.rx_prev <= 1'b1;
            s_q.tx_st <= UCB_ST_IDLE;
            s_q.rx_st <= UCB_ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign reg_rdata_o = s_q.rdata;
    assign serial_out_pin_o = s_q.tx_out;
    assign irq_o = s_q.ien && (s_q.ctrl[UCB_CTRL_TDF] || s_q.ctrl[UCB_CTRL_RDF]);
endmodule : ucb_uart
`default_nettype wire

// ### ucb_uart_chk.sv
// Concurrent checks on the serial port block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module ucb_uart_chk
    import ucb_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic baud_tick_i,
    input wire logic serial_in_pin_i,
    input wire logic serial_out_pin_o,
    input wire logic irq_o
);
    ////////////////////////////////////////////////////////////
    // Shadows of the fields the checks need, updated like the registers.
    logic [1:0] mode_q;
    logic dbl_q, ien_q, tx_seen_q;
    logic [11:0] low_cnt_q;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_q <= 2'h0;
            dbl_q <= 1'b0;
            ien_q <= 1'b0;
            tx_seen_q <= 1'b0;
            low_cnt_q <= 12'h000;
        end else begin
            mode_q <= (reg_wr_i && reg_addr_i == UCB_ADDR_CTRL) ? reg_wdata_i[7:6] : mode_q;
            dbl_q <= (reg_wr_i && reg_addr_i == UCB_ADDR_TCTL) ? reg_wdata_i[UCB_TCTL_DBL] : dbl_q;
            ien_q <= (reg_wr_i && reg_addr_i == UCB_ADDR_IEN) ? reg_wdata_i[0] : ien_q;
            tx_seen_q <= tx_seen_q | (reg_wr_i && reg_addr_i == UCB_ADDR_DATA);
            // A low run on the pin must be a whole number of bit times.
            low_cnt_q <= serial_out_pin_o ? 12'h000 : low_cnt_q + 12'h001;
        end
    end
    ////////////////////////////////////////////////////////////
    // All checks share one clock and one reset.
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_tx_launch;
        reg_wr_i && reg_addr_i == UCB_ADDR_DATA && mode_q == UCB_MODE_UART9F;
    endsequence
    sequence s_ctrl_read;
        reg_rd_i && reg_addr_i == UCB_ADDR_CTRL;
    endsequence
    a_rdata_idle_zero: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 8'h00) else $error("read data not zero");
    a_unmapped_read: assert property (
        reg_rd_i && reg_addr_i > UCB_ADDR_IEN |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_irq_needs_enable: assert property (
        irq_o |-> ien_q || $past(ien_q)) else $error("interrupt while disabled");
    a_irq_flags_or: assert property (s_ctrl_read |=>
        ((reg_rdata_o[UCB_CTRL_TDF] | reg_rdata_o[UCB_CTRL_RDF]) & ien_q) == $past(irq_o))
        else $error("interrupt differs from flags");
    a_flag_sw_clear: assert property (
        $fell(irq_o) |-> $past(reg_wr_i) || $past(reg_wr_i, 2)) else $error("flag cleared alone");
    a_tx_idle_high: assert property (
        !tx_seen_q |-> serial_out_pin_o) else $error("transmit pin left idle level");
    a_tx_start_soon: assert property (
        s_tx_launch |-> ##[1:80] !serial_out_pin_o) else $error("no start bit after write");
    a_bit_len_fixed: assert property (
        $rose(serial_out_pin_o) && mode_q == UCB_MODE_UART9F && !dbl_q |->
        low_cnt_q[5:0] == 6'h00) else $error("bit time not 64 clocks");
    a_bit_len_double: assert property (
        $rose(serial_out_pin_o) && mode_q == UCB_MODE_UART9F && dbl_q |->
        low_cnt_q[4:0] == 5'h00) else $error("doubled bit time not 32 clocks");
endmodule : ucb_uart_chk
bind ucb_uart ucb_uart_chk u_chk (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .baud_tick_i(baud_tick_i), .serial_in_pin_i(serial_in_pin_i),
    .serial_out_pin_o(serial_out_pin_o), .irq_o(irq_o)
);
`default_nettype wire

// ### ucb_peer.sv
// Remote serial partner that sends and captures nine-bit asynchronous frames.
`timescale 1ns/1ps
`default_nettype none
module ucb_peer (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o
);
    ////////////////////////////////////////////////////////////
    // The line rests at the mark level between frames.
    initial line_o = 1'b1;
    // Start bit, nine data bits from the low end, then the stop bit.
    task automatic send_frame(input logic [8:0] bits, input int bit_clk);
        logic [10:0] f;
        f = {1'b1, bits, 1'b0};
        for (int i = 0; i < 11; i++) begin
            line_o <= f[i];
            repeat (bit_clk) @(posedge clk_i);
        end
    endtask : send_frame
    // Samples each bit in its middle, so a wrong bit time shows as bad data.
    task automatic recv_frame(output logic [8:0] bits, output logic stop, input int bit_clk);
        @(negedge line_i);
        repeat (bit_clk / 2) @(posedge clk_i);
        for (int i = 0; i < 9; i++) begin
            repeat (bit_clk) @(posedge clk_i);
            bits[i] = line_i;
        end
        repeat (bit_clk) @(posedge clk_i);
        stop = line_i;
    endtask : recv_frame
endmodule : ucb_peer
`default_nettype wire

// ### ucb_uart_tb.sv
// Self-checking bench for the serial port control and data buffer block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module ucb_uart_tb;
    import ucb_pkg::*;
    logic sys_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic rx_line, tx_line, irq;
    int n_fail = 0, n_compared = 0, n_cycles = 0;
    ////////////////////////////////////////////////////////////
    // Baud tick tied high: the reload timer steps on every clock.
    ucb_uart u_dut (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .baud_tick_i(1'b1), .serial_in_pin_i(rx_line), .serial_out_pin_o(tx_line), .irq_o(irq));
    ucb_peer u_peer (.clk_i(sys_clk), .line_i(tx_line), .line_o(rx_line));
    // 200 MHz clock.
    always #2.5 sys_clk = ~sys_clk;
    // A hang costs one mismatch and ends the run.
    always @(posedge sys_clk) begin
        n_cycles++;
        if (n_cycles == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////
    // Bus cycles; each leaves an idle cycle so no strobe is driven twice at once.
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : reg_write
    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge sys_clk);
    endtask : reg_read
    task automatic tally_and_finish();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        logic [7:0] d;
        reg_read(UCB_ADDR_CTRL, d);
        `CHK(d, UCB_RST_CTRL)
        reg_read(UCB_ADDR_DATA, d);
        `CHK(d, UCB_RST_DATA)
        reg_read(4'hF, d);
        `CHK(d, 8'h00)
    endtask : t_reset_values
    task automatic t_modes();
        logic [7:0] d;
        for (int m = 0; m < 4; m++) begin
            reg_write(UCB_ADDR_CTRL, 8'(m << 6));
            reg_read(UCB_ADDR_CTRL, d);
            `CHK(d[7:6], 2'(m))
        end
    endtask : t_modes
    // Nine-bit send, then the done flag must hold until software clears it.
    task automatic t_tx9(input logic dbl);
        logic [8:0] bits;
        logic stop;
        logic [7:0] d;
        reg_write(UCB_ADDR_TCTL, {dbl, 7'h00});
        reg_write(UCB_ADDR_IEN, 8'h01);
        reg_write(UCB_ADDR_CTRL, 8'h88);
        fork
            u_peer.recv_frame(bits, stop, dbl ? 32 : 64);
            reg_write(UCB_ADDR_DATA, 8'hA5);
        join
        `CHK(bits, 9'h1A5)
        `CHK(stop, 1'b1)
        reg_read(UCB_ADDR_CTRL, d);
        `CHK(d[UCB_CTRL_TDF], 1'b1)
        `CHK(irq, 1'b1)
        repeat (100) @(posedge sys_clk);
        reg_read(UCB_ADDR_CTRL, d);
        `CHK(d[UCB_CTRL_TDF], 1'b1)
        reg_write(UCB_ADDR_CTRL, 8'h88);
        reg_read(UCB_ADDR_CTRL, d);
        `CHK(d[UCB_CTRL_TDF], 1'b0)
        `CHK(irq, 1'b0)
    endtask : t_tx9
    // Filtered, accepted and disabled receptions in the fixed-rate mode.
    task automatic t_rx9();
        logic [7:0] d;
        reg_write(UCB_ADDR_TCTL, 8'h00);
        reg_write(UCB_ADDR_CTRL, 8'hB0);
        u_peer.send_frame(9'h03C, 64);
        reg_read(UCB_ADDR_CTRL, d);
        `CHK(d[UCB_CTRL_RDF], 1'b0)
        reg_read(UCB_ADDR_DATA, d);
        `CHK(d, 8'h00)
        u_peer.send_frame(9'h1C3, 64);
        reg_read(UCB_ADDR_CTRL, d);
        `CHK(d[2:0], 3'b101)
        reg_read(UCB_ADDR_DATA, d);
        `CHK(d, 8'hC3)
        reg_write(UCB_ADDR_CTRL, 8'h80);
        u_peer.send_frame(9'h15A, 64);
        reg_read(UCB_ADDR_CTRL, d);
        `CHK(d[UCB_CTRL_RDF], 1'b0)
        reg_read(UCB_ADDR_DATA, d);
        `CHK(d, 8'hC3)
    endtask : t_rx9
    // Both directions through the shared buffer address at once.
    task automatic t_duplex();
        logic [8:0] bits;
        logic stop;
        logic [7:0] d;
        reg_write(UCB_ADDR_CTRL, 8'h90);
        fork
            u_peer.recv_frame(bits, stop, 64);
            begin
                reg_write(UCB_ADDR_DATA, 8'h69);
                u_peer.send_frame(9'h096, 64);
            end
        join
        `CHK(bits, 9'h069)
        reg_read(UCB_ADDR_DATA, d);
        `CHK(d, 8'h96)
        reg_read(UCB_ADDR_CTRL, d);
        `CHK(d[2:0], 3'b011)
    endtask : t_duplex
    // Eight-bit frames timed by the reload timer, with the stop-bit filter on.
    task automatic t_uart8();
        logic [8:0] bits;
        logic stop;
        logic [7:0] d;
        reg_write(UCB_ADDR_TCTL, 8'h80);
        reg_write(UCB_ADDR_BAUD, 8'hFC);
        reg_write(UCB_ADDR_CTRL, 8'h70);
        reg_read(UCB_ADDR_BAUD, d);
        `CHK(d, 8'hFC)
        // Let the timer wrap once, so the new reload gives a tick every 4 clocks.
        repeat (300) @(posedge sys_clk);
        fork
            u_peer.recv_frame(bits, stop, 64);
            reg_write(UCB_ADDR_DATA, 8'h5A);
        join
        `CHK(bits, 9'h15A)
        u_peer.send_frame(9'h0C3, 64);
        reg_read(UCB_ADDR_CTRL, d);
        `CHK(d[2:0], 3'b010)
        u_peer.send_frame(9'h13C, 64);
        reg_read(UCB_ADDR_CTRL, d);
        `CHK(d[2:0], 3'b111)
        reg_read(UCB_ADDR_DATA, d);
        `CHK(d, 8'h3C)
        reg_write(UCB_ADDR_CTRL, 8'h00);
    endtask : t_uart8
    // Shift mode sends eight bits and flags done, at the full clock or over 12.
    task automatic t_shift();
        logic [7:0] d;
        reg_write(UCB_ADDR_CTRL, 8'h20);
        reg_write(UCB_ADDR_DATA, 8'h81);
        repeat (10) @(posedge sys_clk);
        reg_read(UCB_ADDR_CTRL, d);
        `CHK(d[UCB_CTRL_TDF], 1'b1)
        reg_write(UCB_ADDR_CTRL, 8'h00);
        reg_write(UCB_ADDR_DATA, 8'h81);
        repeat (50) @(posedge sys_clk);
        reg_read(UCB_ADDR_CTRL, d);
        `CHK(d[UCB_CTRL_TDF], 1'b0)
        repeat (80) @(posedge sys_clk);
        reg_read(UCB_ADDR_CTRL, d);
        `CHK(d[UCB_CTRL_TDF], 1'b1)
        reg_write(UCB_ADDR_CTRL, 8'h00);
    endtask : t_shift
    ////////////////////////////////////////////////////////////
    // Reset for 12 clocks, then the scenarios in turn.
    initial begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        t_reset_values();
        t_modes();
        t_tx9(1'b0);
        t_tx9(1'b1);
        t_rx9();
        t_duplex();
        t_uart8();
        t_shift();
        tally_and_finish();
    end
endmodule : ucb_uart_tb
`default_nettype wire
